// >>> src/pmt_defs.vh
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH
// What this block does
// RULE1: Up to three identical timers, each with own count, period, control.
// RULE2: Timer clock is the instruction clock, oscillator divided by four.
// RULE3: Count starts at zero and adds one per prescaler output tick.
// RULE4: Prescale field 00,01,10,11 divides by 1, 4, 16, 64.
// RULE5: Count compared with period every cycle; equality gives match output.
// RULE6: Match clears count next cycle and advances the postscaler by one.
// RULE7: Count and period registers readable and writable at any time.
// RULE8: Reset clears count and sets period to all ones.
// RULE9: Count or control write, and any reset, clear prescaler and postscaler.
// RULE10: Four-bit postscaler counts matches; at ratio sets latched match flag.
// RULE11: Interrupt request raised only while the match enable bit is set.
// RULE12: Postscale field bits 6..3 selects ratio of field plus one.
// RULE13: Control bit 2 turns the timer on when set.
// RULE14: Control bit 7 unimplemented, reads zero.
// RULE15: Unscaled match pulse goes out as the PWM time base.
// RULE16: Only the first timer may supply the serial port shift clock.
// RULE17: Timer stops in sleep; count and period keep their values.
// RULE18: With timer off the count holds; no matches or postscaler updates.
// RULE19: Match flag stays set until software clears it; new event sets it.

`define PMT_N_TIMERS      3
`define PMT_BLK_STRIDE    8'h10
`define PMT_OFF_CONTROL   4'h0
`define PMT_OFF_COUNT     4'h4
`define PMT_OFF_PERIOD    4'h8
`define PMT_OFF_IRQ_FLAG  8'h30
`define PMT_OFF_IRQ_EN    8'h34
`define PMT_CTRL_MASK     8'h7F
`define PMT_CTRL_ON_BIT   2
`define PMT_COUNT_RST     8'h00
`define PMT_PERIOD_RST    8'hFF
`define PMT_CTRL_RST      8'h00
`define PMT_PRE_DIV1      2'h0
`define PMT_PRE_DIV4      2'h1
`define PMT_PRE_DIV16     2'h2
`define PMT_RESP_OKAY     2'h0
`define PMT_RESP_SLVERR   2'h2
`endif

// >>> src/pmt_top.v
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pmt_defs.vh"

module pmt_timer (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       sleep,
  input  wire [7:0] control,
  input  wire       wr_count,
  input  wire       wr_control,
  input  wire [7:0] wdata,
  input  wire       wr_period,
  output wire [7:0] count,
  output wire [7:0] period,
  output wire       match_pulse,
  output wire       post_event
);
  reg  [7:0] count_r;
  reg  [7:0] count_nxt;
  reg  [7:0] period_r;
  reg  [5:0] pre_r;
  reg  [5:0] pre_nxt;
  reg  [3:0] post_r;
  reg  [3:0] post_nxt;
  reg        clr_pend_r;
  reg        clr_pend_nxt;
  reg        match_r;
  reg        post_evt_r;
  wire       run;
  wire       tick;
  wire       match;
  reg        pre_done;
  wire       post_wrap;

  assign run = control[`PMT_CTRL_ON_BIT] & ~sleep; // see RULE13 see RULE17 see RULE18
  // Pending clear masks the stale count, so one match is seen per period
  assign match = run & ~clr_pend_r & (count_r == period_r); // see RULE5
  assign post_wrap = (post_r == control[6:3]); // see RULE12

  always @* begin
    case (control[1:0]) // see RULE4
      `PMT_PRE_DIV1:  pre_done = 1'b1;
      `PMT_PRE_DIV4:  pre_done = (pre_r[1:0] == 2'h3);
      `PMT_PRE_DIV16: pre_done = (pre_r[3:0] == 4'hF);
      default:        pre_done = (pre_r == 6'h3F);
    endcase
  end
  assign tick = run & pre_done;

  always @* begin
    count_nxt    = count_r;
    pre_nxt      = pre_r;
    post_nxt     = post_r;
    clr_pend_nxt = 1'b0;
    if (run) begin
      pre_nxt = pre_done ? 6'h00 : pre_r + 6'h01; // see RULE3
      if (match) begin
        clr_pend_nxt = 1'b1; // see RULE6
        post_nxt = post_wrap ? 4'h0 : post_r + 4'h1; // see RULE10 see RULE12
      end
      if (clr_pend_r) begin
        count_nxt = `PMT_COUNT_RST; // see RULE6
      end else if (tick && !match) begin
        count_nxt = count_r + 8'h01; // see RULE3
      end
    end
    if (wr_count) begin
      count_nxt    = wdata; // see RULE7
      clr_pend_nxt = 1'b0;
    end
    if (wr_count || wr_control) begin
      pre_nxt  = 6'h00; // see RULE9
      post_nxt = 4'h0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_r    <= `PMT_COUNT_RST; // see RULE8
      period_r   <= `PMT_PERIOD_RST;
      pre_r      <= 6'h00; // see RULE9
      post_r     <= 4'h0;
      clr_pend_r <= 1'b0;
      match_r    <= 1'b0;
      post_evt_r <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      pre_r      <= pre_nxt;
      post_r     <= post_nxt;
      clr_pend_r <= clr_pend_nxt;
      match_r    <= match; // see RULE15
      post_evt_r <= match && post_wrap && !wr_count && !wr_control; // see RULE10
      if (wr_period) begin
        period_r <= wdata; // see RULE7
      end
    end
  end

  assign count       = count_r;
  assign period      = period_r;
  assign match_pulse = match_r;
  assign post_event  = post_evt_r;
endmodule // pmt_timer

module pmt_top #(
  parameter N_TIMERS = `PMT_N_TIMERS
) (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire                sleep,
  input  wire [7:0]          s_axi_awaddr,
  input  wire [2:0]          s_axi_awprot,
  input  wire                s_axi_awvalid,
  output wire                s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output wire                s_axi_wready,
  output wire [1:0]          s_axi_bresp,
  output wire                s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [7:0]          s_axi_araddr,
  input  wire [2:0]          s_axi_arprot,
  input  wire                s_axi_arvalid,
  output wire                s_axi_arready,
  output wire [31:0]         s_axi_rdata,
  output wire [1:0]          s_axi_rresp,
  output wire                s_axi_rvalid,
  input  wire                s_axi_rready,
  output wire [N_TIMERS-1:0] pwm_time_base,
  output wire                serial_shift_clk,
  output wire                irq
);
  reg  [7:0]          awaddr_r;
  reg                 aw_full_r;
  reg  [31:0]         wdata_r;
  reg                 wlane_r;
  reg                 w_full_r;
  reg                 bvalid_r;
  reg  [1:0]          bresp_r;
  reg                 rvalid_r;
  reg  [31:0]         rdata_r;
  reg  [1:0]          rresp_r;
  reg  [7:0]          ctrl_r [0:N_TIMERS-1];
  reg  [N_TIMERS-1:0] flag_r;
  reg  [N_TIMERS-1:0] en_r;
  reg                 irq_r;
  reg                 shift_r;
  reg                 awready_r;
  reg                 wready_r;
  reg                 arready_r;
  wire                aw_take;
  wire                w_take;
  wire                ar_take;
  wire                aw_nxt;
  wire                w_nxt;
  wire                rv_nxt;
  wire                wr_ok;
  wire                do_wr;
  wire [7:0]          wb;
  wire [7:0]          cnt_w [0:N_TIMERS-1];
  wire [7:0]          per_w [0:N_TIMERS-1];
  wire [N_TIMERS-1:0] match_w;
  wire [N_TIMERS-1:0] post_w;
  wire [N_TIMERS-1:0] flag_nxt;
  reg  [31:0]         rd_nxt;
  reg                 rd_ok;
  integer             k;
  genvar              g;

  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign wb    = wdata_r[7:0];

  generate
    for (g = 0; g < N_TIMERS; g = g + 1) begin : g_tmr // see RULE1 see RULE2
      localparam [3:0] TMR_IDX = g;
      wire sel = do_wr && wlane_r && (awaddr_r[7:4] == TMR_IDX);
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_r[g] <= `PMT_CTRL_RST;
        end else if (sel && awaddr_r[3:0] == `PMT_OFF_CONTROL) begin
          ctrl_r[g] <= wb & `PMT_CTRL_MASK; // see RULE14
        end
      end
      pmt_timer u_tmr (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .sleep       (sleep),
        .control     (ctrl_r[g]),
        .wr_count    (sel && awaddr_r[3:0] == `PMT_OFF_COUNT),
        .wr_control  (sel && awaddr_r[3:0] == `PMT_OFF_CONTROL),
        .wdata       (wb),
        .wr_period   (sel && awaddr_r[3:0] == `PMT_OFF_PERIOD),
        .count       (cnt_w[g]),
        .period      (per_w[g]),
        .match_pulse (match_w[g]),
        .post_event  (post_w[g])
      );
      // Set beats the write-one clear
      assign flag_nxt[g] = post_w[g] | (flag_r[g] & ~(do_wr && wlane_r && // see RULE19
                           awaddr_r == `PMT_OFF_IRQ_FLAG && wb[g]));
    end
  endgenerate

  always @* begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `PMT_OFF_IRQ_FLAG) begin
      rd_nxt[N_TIMERS-1:0] = flag_r;
    end else if (s_axi_araddr == `PMT_OFF_IRQ_EN) begin
      rd_nxt[N_TIMERS-1:0] = en_r;
    end else begin
      rd_ok = 1'b0;
      for (k = 0; k < N_TIMERS; k = k + 1) begin
        if (s_axi_araddr[7:4] == k[3:0]) begin
          case (s_axi_araddr[3:0])
            `PMT_OFF_CONTROL: begin
              rd_nxt[7:0] = ctrl_r[k];
              rd_ok = 1'b1;
            end
            `PMT_OFF_COUNT: begin
              rd_nxt[7:0] = cnt_w[k]; // see RULE7
              rd_ok = 1'b1;
            end
            `PMT_OFF_PERIOD: begin
              rd_nxt[7:0] = per_w[k];
              rd_ok = 1'b1;
            end
            default: rd_ok = 1'b0;
          endcase
        end
      end
    end
  end

  assign wr_ok = (awaddr_r == `PMT_OFF_IRQ_FLAG) || (awaddr_r == `PMT_OFF_IRQ_EN) ||
                 ((awaddr_r[7:4] < N_TIMERS) && ((awaddr_r[3:0] == `PMT_OFF_CONTROL) ||
                  (awaddr_r[3:0] == `PMT_OFF_COUNT) || (awaddr_r[3:0] == `PMT_OFF_PERIOD)));

  // Readies are registered so that every bus output leaves a flop
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take  = s_axi_wvalid & wready_r;
  assign ar_take = s_axi_arvalid & arready_r;
  assign aw_nxt  = do_wr ? 1'b0 : (aw_full_r | aw_take);
  assign w_nxt   = do_wr ? 1'b0 : (w_full_r | w_take);
  assign rv_nxt  = ar_take ? 1'b1 : (rvalid_r & ~s_axi_rready);

  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= 8'h00;
      aw_full_r <= 1'b0;
      awready_r <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      aw_full_r <= aw_nxt;
      awready_r <= ~aw_nxt;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wdata_r  <= 32'h0000_0000;
      wlane_r  <= 1'b0;
      w_full_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wlane_r <= s_axi_wstrb[0];
      end
      w_full_r <= w_nxt;
      wready_r <= ~w_nxt;
    end
  end

  // A pending response holds the write engine off until it is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PMT_RESP_OKAY;
    end else begin
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= {N_TIMERS{1'b0}};
    end else if (do_wr && wlane_r && awaddr_r == `PMT_OFF_IRQ_EN) begin
      en_r <= wb[N_TIMERS-1:0]; // see RULE11
    end
  end

  // Read data is captured at the address handshake and held
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `PMT_RESP_OKAY;
    end else begin
      if (ar_take) begin
        rdata_r <= rd_nxt;
        rresp_r <= rd_ok ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
      end
      rvalid_r  <= rv_nxt;
      arready_r <= ~rv_nxt;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_r  <= {N_TIMERS{1'b0}};
      irq_r   <= 1'b0;
      shift_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt; // see RULE10
      irq_r   <= |(flag_nxt & en_r); // see RULE11
      // Toggle per match halves the rate, as a shift clock should
      shift_r <= shift_r ^ match_w[0]; // see RULE16
    end
  end

  assign s_axi_awready    = awready_r;
  assign s_axi_wready     = wready_r;
  assign s_axi_bvalid     = bvalid_r;
  assign s_axi_bresp      = bresp_r;
  assign s_axi_arready    = arready_r;
  assign s_axi_rvalid     = rvalid_r;
  assign s_axi_rdata      = rdata_r;
  assign s_axi_rresp      = rresp_r;
  assign pwm_time_base    = match_w; // see RULE15
  assign serial_shift_clk = shift_r;
  assign irq              = irq_r;
endmodule // pmt_top

// >>> test/pmt_top_sva.sv
`timescale 1ns/1ps
module pmt_top_sva #(
  parameter N_TIMERS = 3
) (
  input wire                aclk,
  input wire                aresetn,
  input wire                s_axi_awvalid,
  input wire                s_axi_awready,
  input wire                s_axi_wvalid,
  input wire                s_axi_wready,
  input wire                s_axi_bvalid,
  input wire                s_axi_bready,
  input wire                s_axi_arvalid,
  input wire                s_axi_arready,
  input wire [31:0]         s_axi_rdata,
  input wire                s_axi_rvalid,
  input wire                s_axi_rready,
  input wire [N_TIMERS-1:0] pwm_time_base,
  input wire                serial_shift_clk,
  input wire                irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_b_holds: assert property (s_b_wait |=> s_axi_bvalid)
    else $error("write response dropped");
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_shift_toggle: assert property ($changed(serial_shift_clk)
    |-> pwm_time_base[0] || $past(pwm_time_base[0]))
    else $error("shift clock moved without match");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high after reset");
  c_irq: cover property (irq);
endmodule // pmt_top_sva

bind pmt_top pmt_top_sva #(.N_TIMERS(N_TIMERS)) chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .pwm_time_base, .serial_shift_clk, .irq);

// >>> test/pmt_top_tb.sv
`timescale 1ns/1ps
`define CHK(n,e,a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module pmt_top_tb;
  reg         aclk, aresetn, slp, awv, wv, bry, arv, rry;
  reg  [7:0]  awa, ara, b;
  reg  [31:0] wd, d, e;
  reg  [1:0]  r;
  wire        awr, wrd, bv, arr, rv, sck, irq;
  wire [1:0]  br, rr;
  wire [31:0] rdat;
  wire [2:0]  pwm;
  integer     n_fail, checked, p, n;

  pmt_top dut_u (.aclk(aclk), .aresetn(aresetn), .sleep(slp), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .pwm_time_base(pwm),
    .serial_shift_clk(sck), .irq(irq));

  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end

  task summarize;
    begin
      if (n_fail == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Ready sampled at negedge: inputs only move at posedge, so it equals the edge value
  task wr(input [7:0] a, input [31:0] v, output [1:0] s);
    reg ta, tw, t;
    begin
      awa <= a; wd <= v; awv <= 1; wv <= 1; ta = 0; tw = 0; t = 0;
      while (!(ta && tw)) begin
        @(negedge aclk); ta = ta | (awv & awr); tw = tw | (wv & wrd);
        @(posedge aclk); if (ta) awv <= 0; if (tw) wv <= 0;
      end
      bry <= 1;
      while (!t) begin
        @(negedge aclk); t = bv; s = br; @(posedge aclk);
      end
      bry <= 0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] q, output [1:0] s);
    reg t;
    begin
      ara <= a; arv <= 1; t = 0;
      while (!t) begin
        @(negedge aclk); t = arr; @(posedge aclk);
      end
      arv <= 0; rry <= 1; t = 0;
      while (!t) begin
        @(negedge aclk); t = rv; q = rdat; s = rr; @(posedge aclk);
      end
      rry <= 0;
    end
  endtask

  // Cycles between two match pulses of one timer
  task gap(input integer i, output integer c);
    begin
      c = 1;
      @(negedge aclk); while (!pwm[i]) @(negedge aclk);
      @(negedge aclk); while (!pwm[i]) begin c++; @(negedge aclk); end
      @(posedge aclk);
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    summarize;
  end

  initial begin
    n_fail = 0; checked = 0; aresetn = 0; slp = 0; awv = 0; wv = 0; bry = 0;
    arv = 0; rry = 0; awa = 0; ara = 0; wd = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (b = 8'h00; b < 8'h30; b = b + 8'h10) begin
      rd(b, d, r); `CHK("ctrl", 32'h0, d)
      rd(b + 8'h04, d, r); `CHK("count", 32'h0, d)
      rd(b + 8'h08, d, r); `CHK("period", 32'hFF, d)
    end
    wr(8'h00, 32'hFF, r); rd(8'h00, d, r); `CHK("ctrl7", 32'h7F, d)
    wr(8'h00, 32'h04, r);
    wr(8'h14, 32'h55, r); repeat (5) @(posedge aclk);
    rd(8'h14, d, r); `CHK("offhold", 32'h55, d)
    wr(8'h18, 32'hA6, r); rd(8'h18, d, r); `CHK("prw", 32'hA6, d)
    rd(8'h3C, d, r); `CHK("unmap", 2'h2, r)
    wr(8'h18, 32'h02, r);
    for (p = 0; p < 4; p++) begin
      wr(8'h10, 32'h04 | p, r);
      gap(1, n); `CHK("gap", (p == 0) ? 4 : (2 << (2 * p)), n)
    end
    slp <= 1;
    rd(8'h14, e, r); repeat (150) @(posedge aclk); rd(8'h14, d, r);
    `CHK("sleep", e, d)
    slp <= 0;
    wr(8'h10, 32'h00, r);
    wr(8'h28, 32'h01, r); wr(8'h34, 32'h04, r); wr(8'h20, 32'h1C, r);
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge aclk); if (irq !== 1'b1 && pwm[2]) n++;
    end
    @(posedge aclk);
    `CHK("post", 4, n)
    wr(8'h34, 32'h00, r); repeat (2) @(posedge aclk);
    `CHK("mask", 1'b0, irq)
    wr(8'h20, 32'h00, r); rd(8'h30, d, r); `CHK("sticky", 1'b1, d[2])
    wr(8'h30, 32'h04, r); rd(8'h30, d, r); `CHK("clear", 1'b0, d[2])
    summarize;
  end
endmodule // pmt_top_tb
